/* File: design/capture_timer_pkg.sv */
package capture_timer_pkg;

  // Register offsets of blocks 0 to 7 (CPU byte bus, bank 1)
  localparam logic [7:0] BLOCK0_INPUT_SELECT_OFS    = 8'h21;
  localparam logic [7:0] BLOCK1_INPUT_SELECT_OFS    = 8'h25;
  localparam logic [7:0] BLOCK2_INPUT_SELECT_OFS    = 8'h29;
  localparam logic [7:0] BLOCK3_INPUT_SELECT_OFS    = 8'h2D;
  localparam logic [7:0] BLOCK4_INPUT_SELECT_OFS    = 8'h31;
  localparam logic [7:0] BLOCK5_FUNCTION_SELECT_OFS = 8'h34;
  localparam logic [7:0] BLOCK5_INPUT_SELECT_OFS    = 8'h35;
  localparam logic [7:0] BLOCK6_FUNCTION_SELECT_OFS = 8'h38;
  localparam logic [7:0] BLOCK7_FUNCTION_SELECT_OFS = 8'h3C;

  // Bank 0 data/control registers of this block
  localparam logic [7:0] COUNT_OFS   = 8'h00;
  localparam logic [7:0] PERIOD_OFS  = 8'h01;
  localparam logic [7:0] CAPTURE_OFS = 8'h02;
  localparam logic [7:0] CONTROL_OFS = 8'h03;
  localparam logic [7:0] FUNC_OFS    = 8'h04;
  localparam logic [7:0] INSEL_OFS   = 8'h05;

  localparam logic [7:0] INSEL_RESET = 8'h00;
  localparam logic [7:0] FUNC_RESET  = 8'h00;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  localparam int CLK_SEL_LSB  = 0;
  localparam int CLK_SEL_MSB  = 3;
  localparam int DATA_SEL_LSB = 4;
  localparam int DATA_SEL_MSB = 7;
  localparam int ENABLE_BIT   = 0;
  localparam int MODE_IRQ_BIT = 0;
  localparam int MODE_CMP_BIT = 1;

  localparam logic [3:0] CLK_PREV_BLOCK = 4'h3;
  localparam logic [3:0] CLK_FAST       = 4'h4;
  localparam logic [3:0] CLK_DIV_ONE    = 4'h5;
  localparam logic [3:0] CLK_DIV_TWO    = 4'h6;
  localparam logic [3:0] CLK_SLOW       = 4'h7;

  localparam int NUM_SOURCES = 16;

endpackage

/* File: design/capture_timer_block.sv */
`timescale 1ns/10ps
// How it works
// - Input select low nibble picks source clock, high nibble picks capture input.
// - Period register holds divide value; count register holds down counter state.
// - Period write while disabled also loads the counter.
// - Counter reloads from period on the source tick after reaching zero.
// - Each capture copies the count into the capture register.
// - CPU read of count register returns zero and triggers software capture.
// - Counter decrements once per selected source clock rising edge when enabled.
// - Hardware capture rising edge is synchronised to system clock before transfer.
// - Hardware and software capture requests are ORed; firmware holds input low.
// - Terminal count output goes high the cycle after the chained count is zero, while it stays zero.
// - Compare output high when count below capture value; mode bit allows equal.
// - Interrupt on rising edge of terminal count or compare, by low mode bit.
// - Capture register doubles as compare value when capture is unused.
// - Chained capture moves all bytes together; low count byte read triggers it.
// - Blocks chain in 8-bit steps into one wider down counter.
// - Control enable bit; clearing it gates the selected source clock tick to the counter.
// - Disabled block drives terminal count, compare and interrupt low; chain outputs stay live.
// - Disabling keeps the count; capture off, so bytes read count then capture.
module capture_timer_block
  import capture_timer_pkg::*;
(
  input  wire logic                   core_clk_i,
  input  wire logic                   rstn_i,
  input  wire logic [7:0]             addr_i,
  input  wire logic [7:0]             wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [7:0]             rdata_o,
  input  wire logic [NUM_SOURCES-1:0] clk_src_i,
  input  wire logic [NUM_SOURCES-1:0] data_src_i,
  input  wire logic                   fast_system_clock_i,
  input  wire logic                   divided_clock_one_i,
  input  wire logic                   divided_clock_two_i,
  input  wire logic                   slow_system_clock_i,
  input  wire logic                   prev_primary_i,
  input  wire logic                   chain_in_zero_i,
  input  wire logic                   chain_capture_i,
  output logic                        chain_out_zero_o,
  output logic                        chain_capture_o,
  output logic                        terminal_count_o,
  output logic                        compare_o,
  output logic                        irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] count_reg;
  logic [7:0] period_reg;
  logic [7:0] capture_reg;
  logic [7:0] control_reg;
  logic [7:0] func_reg;
  logic [7:0] insel_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic enabled;
  assign enabled = control_reg[ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Source selection
  logic [3:0] clk_sel;
  logic [3:0] data_sel;
  assign clk_sel  = insel_reg[CLK_SEL_MSB:CLK_SEL_LSB];
  assign data_sel = insel_reg[DATA_SEL_MSB:DATA_SEL_LSB];

  logic clk_pick;
  always_comb
  begin
    case (clk_sel)
      CLK_PREV_BLOCK: clk_pick = prev_primary_i;
      CLK_FAST:       clk_pick = fast_system_clock_i;
      CLK_DIV_ONE:    clk_pick = divided_clock_one_i;
      CLK_DIV_TWO:    clk_pick = divided_clock_two_i;
      CLK_SLOW:       clk_pick = slow_system_clock_i;
      default:        clk_pick = clk_src_i[clk_sel];
    endcase
  end

  logic cap_pick;
  assign cap_pick = data_src_i[data_sel];

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; edge taken once stages two and three agree
  logic [2:0] clk_sync_reg;
  logic [2:0] cap_sync_reg;
  logic       clk_state_reg;
  logic       cap_state_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      clk_sync_reg <= 3'h0;
      cap_sync_reg <= 3'h0;
    end
    else
    begin
      clk_sync_reg <= {clk_sync_reg[1:0], clk_pick};
      cap_sync_reg <= {cap_sync_reg[1:0], cap_pick};
    end
  end

  logic clk_agree;
  logic cap_agree;
  assign clk_agree = (clk_sync_reg[1] == clk_sync_reg[2]);
  assign cap_agree = (cap_sync_reg[1] == cap_sync_reg[2]);

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      clk_state_reg <= 1'b0;
      cap_state_reg <= 1'b0;
    end
    else
    begin
      if (clk_agree)
      begin
        clk_state_reg <= clk_sync_reg[2];
      end
      if (cap_agree)
      begin
        cap_state_reg <= cap_sync_reg[2];
      end
    end
  end

  // A rise counts only once stages two and three agree on the new level
  function automatic logic rise_seen(input logic [2:0] sync, input logic state);
    return (sync[1] == sync[2]) && sync[2] && !state;
  endfunction

  logic src_tick;
  logic hw_cap;
  // Gating the tick with enable stands in for stopping the block clock
  assign src_tick = enabled && rise_seen(clk_sync_reg, clk_state_reg);
  assign hw_cap   = rise_seen(cap_sync_reg, cap_state_reg);

  ////////////////////////////////////////////////////////////////////////////
  // CPU access decode
  // One strobe qualified by one register offset
  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction

  logic wr_count;
  logic wr_period;
  logic wr_capture;
  logic wr_control;
  logic wr_func;
  logic wr_insel;
  logic rd_count;
  assign wr_count   = reg_hit(wr_i, addr_i, COUNT_OFS);
  assign wr_period  = reg_hit(wr_i, addr_i, PERIOD_OFS);
  assign wr_capture = reg_hit(wr_i, addr_i, CAPTURE_OFS);
  assign wr_control = reg_hit(wr_i, addr_i, CONTROL_OFS);
  assign wr_func    = reg_hit(wr_i, addr_i, FUNC_OFS);
  assign wr_insel   = reg_hit(wr_i, addr_i, INSEL_OFS);
  assign rd_count   = reg_hit(rd_i, addr_i, COUNT_OFS);

  // Hardware capture only while enabled; disabled reads transfer by read of count
  logic sw_cap;
  logic capture_now;
  assign sw_cap      = rd_count || chain_capture_i;
  assign capture_now = sw_cap || (enabled && hw_cap);
  assign chain_capture_o = capture_now;

  ////////////////////////////////////////////////////////////////////////////
  // Down counter; chained blocks decrement only when lower bytes are zero
  logic at_zero;
  assign at_zero          = (count_reg == BYTE_ZERO);
  assign chain_out_zero_o = at_zero && chain_in_zero_i;

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      count_reg <= BYTE_ZERO;
    end
    else if (wr_period && !enabled)
    begin
      count_reg <= wdata_i;
    end
    else if (wr_count)
    begin
      count_reg <= wdata_i;
    end
    else if (src_tick && chain_in_zero_i)
    begin
      if (at_zero)
      begin
        count_reg <= period_reg;
      end
      else
      begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period, control, function and input select registers, one block each
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      period_reg <= BYTE_ZERO;
    end
    else if (wr_period)
    begin
      period_reg <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      control_reg <= BYTE_ZERO;
    end
    else if (wr_control)
    begin
      control_reg <= {7'h00, wdata_i[ENABLE_BIT]};
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      func_reg <= FUNC_RESET;
    end
    else if (wr_func)
    begin
      func_reg <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      insel_reg <= INSEL_RESET;
    end
    else if (wr_insel)
    begin
      insel_reg <= wdata_i;
    end
  end

  // Capture wins over a CPU write of the compare value in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      capture_reg <= BYTE_ZERO;
    end
    else if (capture_now)
    begin
      capture_reg <= count_reg;
    end
    else if (wr_capture)
    begin
      capture_reg <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: count reads as zero
  always_comb
  begin
    case (addr_i)
      COUNT_OFS:   rdata_next = BYTE_ZERO;
      PERIOD_OFS:  rdata_next = period_reg;
      CAPTURE_OFS: rdata_next = capture_reg;
      CONTROL_OFS: rdata_next = control_reg;
      FUNC_OFS:    rdata_next = func_reg;
      INSEL_OFS:   rdata_next = insel_reg;
      default:     rdata_next = BYTE_ZERO;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_reg <= BYTE_ZERO;
    end
    else if (rd_i)
    begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and interrupt
  logic cmp_true;
  assign cmp_true = func_reg[MODE_CMP_BIT] ? (count_reg <= capture_reg)
                                           : (count_reg < capture_reg);

  logic tc_reg;
  logic cmp_reg;
  logic irq_reg;
  logic irq_src;
  logic irq_src_d_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      tc_reg  <= 1'b0;
      cmp_reg <= 1'b0;
    end
    else
    begin
      tc_reg  <= enabled && at_zero && chain_in_zero_i;
      cmp_reg <= enabled && cmp_true;
    end
  end

  assign irq_src = func_reg[MODE_IRQ_BIT] ? cmp_reg : tc_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      irq_src_d_reg <= 1'b0;
      irq_reg       <= 1'b0;
    end
    else
    begin
      irq_src_d_reg <= irq_src;
      irq_reg       <= enabled && irq_src && !irq_src_d_reg;
    end
  end

  assign terminal_count_o = tc_reg;
  assign compare_o        = cmp_reg;
  assign irq_o            = irq_reg;

endmodule

/* File: bench/capture_timer_props.sv */
`timescale 1ns/10ps
module capture_timer_props
  import capture_timer_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic [7:0] rdata_o,
  input  wire logic       terminal_count_o,
  input  wire logic       compare_o,
  input  wire logic       irq_o,
  input  wire logic       chain_in_zero_i,
  input  wire logic       chain_out_zero_o,
  input  wire logic       chain_capture_o
);
  logic       en_reg;
  logic [7:0] insel_reg;
  logic [7:0] func_reg;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i)
    if (!rstn_i) en_reg <= 1'b0;
    else if (wr_i && addr_i == CONTROL_OFS) en_reg <= wdata_i[ENABLE_BIT];
  always_ff @(posedge core_clk_i)
    if (!rstn_i) insel_reg <= INSEL_RESET;
    else if (wr_i && addr_i == INSEL_OFS) insel_reg <= wdata_i;
  always_ff @(posedge core_clk_i)
    if (!rstn_i) func_reg <= FUNC_RESET;
    else if (wr_i && addr_i == FUNC_OFS) func_reg <= wdata_i;
  ////////////////////////////////////////////////////////////
  AST_RD_COUNT_ZERO: assert property (rd_i && addr_i == COUNT_OFS |=> rdata_o == BYTE_ZERO)
    else $error("count read not zero");
  AST_RDATA_HOLD: assert property (!rd_i |=> $stable(rdata_o))
    else $error("read data moved without read");
  AST_UNMAPPED_RD: assert property (rd_i && addr_i > INSEL_OFS |=> rdata_o == BYTE_ZERO)
    else $error("unmapped read not zero");
  AST_INSEL_RB: assert property (rd_i && !wr_i && addr_i == INSEL_OFS |=> rdata_o == $past(insel_reg))
    else $error("input select readback");
  AST_FUNC_RB: assert property (rd_i && !wr_i && addr_i == FUNC_OFS |=> rdata_o == $past(func_reg))
    else $error("function readback");
  // Three cycles let the registered outputs settle after the enable drops
  AST_DISABLED_LOW: assert property (!en_reg [*3] |-> !terminal_count_o && !compare_o && !irq_o)
    else $error("output high while disabled");
  AST_IRQ_PULSE: assert property (irq_o |=> !irq_o)
    else $error("irq longer than one cycle");
  // Every source period is at least eight cycles here
  // A disable may cut the pulse short; that is allowed
  AST_TC_STANDS: assert property ($rose(terminal_count_o) |-> (terminal_count_o || !en_reg) [*4])
    else $error("terminal count too short");
  AST_TC_AT_ZERO: assert property (en_reg && chain_out_zero_o |=> terminal_count_o)
    else $error("terminal count missing at zero");
  AST_TC_NEEDS_ZERO: assert property (!chain_out_zero_o |=> !terminal_count_o)
    else $error("terminal count away from zero");
  AST_CHAIN_IN_GATES: assert property (!chain_in_zero_i |-> !chain_out_zero_o)
    else $error("chain zero without lower bytes");
  AST_CHAIN_CAP: assert property (rd_i && addr_i == COUNT_OFS |-> chain_capture_o)
    else $error("count read gave no chain capture");
  cover property ($rose(terminal_count_o));
  cover property (chain_capture_o && !rd_i);
  cover property ($rose(compare_o));
  cover property (irq_o);
endmodule

bind capture_timer_block capture_timer_props u_props (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .terminal_count_o(terminal_count_o), .compare_o(compare_o), .irq_o(irq_o),
  .chain_in_zero_i(chain_in_zero_i), .chain_out_zero_o(chain_out_zero_o), .chain_capture_o(chain_capture_o));

/* File: bench/source_model.sv */
`timescale 1ns/10ps
// Routed clock sources; all far below the system clock
module source_model
(
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  output logic      [15:0] clk_src_o,
  output logic      [4:0]  sel_clk_o
);
  logic [5:0] cnt_reg;
  always_ff @(posedge core_clk_i)
    if (!rstn_i) cnt_reg <= 6'h00;
    else cnt_reg <= cnt_reg + 6'h01;
  assign clk_src_o = {16{cnt_reg[3]}};
  // prev, fast, div one, div two, slow: periods 32, 8, 16, 32, 64 cycles
  assign sel_clk_o = {cnt_reg[5], cnt_reg[4], cnt_reg[3], cnt_reg[2], cnt_reg[4]};
endmodule

/* File: bench/tb_capture_timer_block.sv */
`timescale 1ns/10ps
module tb_capture_timer_block;
  import capture_timer_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] data_src_i = 16'h0000;
  logic [7:0]  rdata_o;
  logic [15:0] clk_src;
  logic [4:0]  sc;
  logic        tc, cmp, irq, c, q;
  logic        chain_zero = 1'b1;
  logic        chain_cap = 1'b0;
  logic [7:0]  v;
  logic [15:0] w, p;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          sp [6] = '{32, 8, 16, 32, 64, 16};
  logic [3:0]  cs [6] = '{CLK_PREV_BLOCK, CLK_FAST, CLK_DIV_ONE, CLK_DIV_TWO, CLK_SLOW, 4'h0};
  initial forever #20 core_clk_i = ~core_clk_i;
  source_model src (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_src_o(clk_src), .sel_clk_o(sc));
  capture_timer_block dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .clk_src_i(clk_src), .data_src_i(data_src_i),
    .fast_system_clock_i(sc[1]), .divided_clock_one_i(sc[2]), .divided_clock_two_i(sc[3]),
    .slow_system_clock_i(sc[4]), .prev_primary_i(sc[0]), .chain_in_zero_i(chain_zero), .chain_capture_i(chain_cap),
    .chain_out_zero_o(), .chain_capture_o(), .terminal_count_o(tc), .compare_o(cmp), .irq_o(irq));
  ////////////////////////////////////////////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task tick;
    @(posedge core_clk_i);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    tick;
    wr_i = 1'b1;
    addr_i = a;
    wdata_i = d;
    tick;
    wr_i = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    tick;
    rd_i = 1'b1;
    addr_i = a;
    tick;
    rd_i = 1'b0;
    d = rdata_o;
  endtask
  // Width of one terminal count pulse and spacing of two rises
  task meas;
    w = 0;
    p = 0;
    while (tc !== 1'b1 && p < 2000) begin tick; p++; end
    while (tc === 1'b1 && w < 300) begin tick; w++; end
    p = w;
    while (tc !== 1'b1 && p < 2000) begin tick; p++; end
  endtask
  task see(input int n);
    c = 1'b0;
    q = 1'b0;
    repeat (n) begin tick; c |= cmp; q |= irq; end
  endtask
  task results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results;
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    rd(INSEL_OFS, v); chk(v, INSEL_RESET);
    rd(8'h07, v); chk(v, BYTE_ZERO);
    wr(INSEL_OFS, 8'hA5); rd(INSEL_OFS, v); chk(v, 8'hA5);
    wr(FUNC_OFS, 8'h03); rd(FUNC_OFS, v); chk(v, 8'h03);
    wr(PERIOD_OFS, 8'h05); rd(COUNT_OFS, v); chk(v, BYTE_ZERO);
    rd(CAPTURE_OFS, v); chk(v, 8'h05);
    for (int i = 0; i < 6; i++)
    begin
      wr(CONTROL_OFS, 8'h00);
      wr(INSEL_OFS, {4'h0, cs[i]});
      wr(PERIOD_OFS, 8'h03);
      wr(CONTROL_OFS, 8'h01);
      meas;
      chk(w, 16'(sp[i]));
      chk(p, 16'(4 * sp[i]));
      rd(COUNT_OFS, v);
      rd(CAPTURE_OFS, v); chk(v, BYTE_ZERO);
    end
    wr(FUNC_OFS, 8'h00); wr(CAPTURE_OFS, 8'h02); see(600); chk({c, q}, 2'b11);
    wr(FUNC_OFS, 8'h01); see(600); chk(q, 1'b1);
    wr(FUNC_OFS, 8'h02); wr(CAPTURE_OFS, 8'h00); see(600); chk(c, 1'b1);
    wr(FUNC_OFS, 8'h00); see(600); chk(c, 1'b0);
    wr(CONTROL_OFS, 8'h00);
    wr(INSEL_OFS, {4'h1, CLK_SLOW});
    wr(PERIOD_OFS, 8'h07);
    wr(CAPTURE_OFS, 8'hFF);
    wr(CONTROL_OFS, 8'h01);
    tick;
    data_src_i[1] = 1'b1;
    repeat (4) tick;
    data_src_i[1] = 1'b0;
    repeat (6) tick;
    wr(CONTROL_OFS, 8'h00);
    rd(CAPTURE_OFS, v); chk(16'(v == 8'h07 || v == 8'h06), 16'h0001);
    rd(COUNT_OFS, v); rd(CAPTURE_OFS, v);
    w = 16'(v);
    see(200); chk({c, q}, 2'b00);
    rd(COUNT_OFS, v); rd(CAPTURE_OFS, v); chk(16'(v), w);
    wr(PERIOD_OFS, 8'h2C);
    tick;
    chain_cap = 1'b1;
    tick;
    chain_cap = 1'b0;
    rd(CAPTURE_OFS, v); chk(v, 8'h2C);
    chain_zero = 1'b0;
    wr(CONTROL_OFS, 8'h01);
    see(200); chk({c, q}, 2'b00);
    wr(CONTROL_OFS, 8'h00);
    rd(COUNT_OFS, v); rd(CAPTURE_OFS, v); chk(v, 8'h2C);
    results;
  end
endmodule
